// >>> hw/cse_pkg.sv
// Purpose: Shared constants and carriers for the CAN status/event block.
// Assumes: 8-bit registers on a 32-bit Avalon-MM word per index.
// Notes:   Byte address of a register is four times its index.
`default_nettype none

package cse_pkg;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_CMD = 6'h01;
  localparam logic [5:0] IDX_STAT = 6'h02;
  localparam logic [5:0] IDX_EVT = 6'h03;
  localparam logic [5:0] IDX_EN = 6'h04;
  localparam logic [5:0] IDX_EWL = 6'h0d;
  localparam logic [5:0] IDX_REC = 6'h0e;
  localparam logic [5:0] IDX_TEC = 6'h0f;
  localparam logic [5:0] IDX_TXB_FIRST = 6'h10;
  localparam logic [5:0] IDX_TXB_LAST = 6'h1c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_RESET = 0;
  localparam int CTRL_SLEEP = 4;
  localparam int CMD_TX = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_RELEASE = 2;
  localparam int CMD_CLR_OVF = 3;
  localparam int CMD_SELF = 4;
  localparam int ST_PEND = 0;
  localparam int ST_OVF = 1;
  localparam int ST_TXFREE = 2;
  localparam int ST_TXDONE = 3;
  localparam int ST_RXACT = 4;
  localparam int ST_TXACT = 5;
  localparam int ST_WARN = 6;
  localparam int ST_BOFF = 7;
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_WARN = 2;
  localparam int EV_OVF = 3;
  localparam int EV_WAKE = 4;
  localparam int EV_PASSIVE = 5;
  localparam int EV_ARB = 6;
  localparam int EV_BERR = 7;

  // ****************************************
  // Reset values and counter limits
  // ****************************************
  localparam logic [7:0] EWL_RESET = 8'h60;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [9:0] TEC_LIMIT = 10'h0ff;
  localparam logic [8:0] TEC_BOFF_LOAD = 9'h07f;
  localparam logic [9:0] TEC_ERR_STEP = 10'h008;
  localparam logic [8:0] PASSIVE_LEVEL = 9'h07f;
  localparam logic [7:0] RECOVER_FREE = 8'h80;
  localparam logic [7:0] REC_MAX = 8'hff;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic rx_msg_done;
    logic [6:0] rx_msg_len;
    logic tx_sent;
    logic tx_aborted;
    logic tx_err;
    logic tx_ok;
    logic rx_err;
    logic rx_ok;
    logic bus_err;
    logic arb_loss;
    logic bus_free;
    logic bus_activity;
    logic rx_busy;
    logic tx_busy;
  } cse_engine_ev_t;

  typedef struct packed {
    logic tx_req;
    logic self_loop;
    logic abort;
    logic buf_we;
    logic [3:0] buf_idx;
    logic [7:0] buf_data;
    logic rx_release;
    logic reset_mode;
    logic sleep;
  } cse_tx_ctl_t;

endpackage : cse_pkg

`default_nettype wire

// >>> hw/cse_status_events.sv
// Purpose: Status flags, error counters, bus-off recovery and event flags
//          of a CAN controller, reached over Avalon-MM.
// Assumes: Frame engine inputs run on sys_clk; events are 1-cycle pulses.
// Notes:   Registers are 8 bits wide in the low byte of each word.
`default_nettype none

// Notes on behaviour
// (R1) Overflow status sets when a message is lost for lack of queue room.
// (R2) Overflow status stays set until the overflow-clear command.
// (R3) Receive-available is one while the queue holds a complete message.
// (R4) TX counter beyond 255: bus-off, reset mode, TEC=127, REC=0, event.
// (R5) After bus-off, wait for reset-mode clear then 128 bus-free periods.
// (R6) Recovery end clears bus-off, warning, both counters, raises event.
// (R7) Warning status while a counter reaches the limit; limit resets to 96.
// (R8) Idle after 1 bus-free period from reset, 128 after bus-off.
// (R9) Both active bits set means waiting for the bus to go idle.
// (R10) TX complete cleared by transmit or self-loop request until success.
// (R11) Transmit buffer writes while the buffer is locked are dropped.
// (R12) Dropped message flags overflow when valid; errored ones flag none.
// (R13) Interrupt output is high while any event flag is set.
// (R14) Reading the event register clears the flags it returned, except receive-available.
// (R15) Event 7 on a bus error when enabled.
// (R16) Event 6 on lost arbitration when enabled.
// (R17) Event 5 on entering or leaving error-passive when enabled.
// (R18) Event 4 on bus activity while sleeping when enabled.
// (R19) Event 3 on overflow status rising when enabled.
// (R20) Event 2 on any change of warning or bus-off status when enabled.
// (R21) Event 1 on transmit buffer going from locked to free when enabled.
// (R22) Event 0 follows queue not empty and its enable.
// (R23) Release command blanks event 0 for one cycle.
// (R24) Sleep attempt with bus busy or interrupt pending raises wake event.
// (R25) No further overflow events while overflow status stays set.
module cse_status_events
  import cse_pkg::*;
#(
  parameter int RXQ_BYTES = 64,
  parameter int RXQ_MSGS = 8
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Frame engine
  input wire cse_engine_ev_t eng_ev,
  output cse_tx_ctl_t tx_ctl,
  output logic bus_off_out,
  output logic irq
);

  localparam int PW = $clog2(RXQ_MSGS);
  localparam int UW = $clog2(RXQ_BYTES + 1);

  typedef struct packed {
    logic ack;
    logic wait_req;
    logic [7:0] rdata;
    logic reset_mode;
    logic sleep;
    logic [7:0] enable;
    logic [7:0] warn_limit;
    logic [8:0] tec;
    logic [7:0] rec;
    logic bus_off;
    logic recovering;
    logic waiting;
    logic [7:0] free_cnt;
    logic overflow;
    logic [UW-1:0] used;
    logic [PW:0] msg_cnt;
    logic [PW-1:0] head;
    logic [PW-1:0] tail;
    logic [RXQ_MSGS-1:0][6:0] lens;
    logic tx_free;
    logic tx_complete;
    logic err_warn;
    logic passive;
    logic [7:0] events;
    logic blank;
    logic irq;
    cse_tx_ctl_t ctl;
  } cse_state_t;

  cse_state_t s_q;
  cse_state_t s_d;
  logic [5:0] idx;
  logic [7:0] wdat;
  logic commit;
  logic wr_go;
  logic rd_go;
  logic [7:0] stat_now;
  logic [7:0] rd_mux;
  logic [9:0] tec_sum;
  logic [8:0] rec_sum;
  logic fits;
  logic wake;
  logic pop;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    s_d = s_q;
    idx = avs_address[7:2];
    wdat = avs_writedata[7:0];
    // Write and read side effects land on the edge waitrequest is low
    commit = (avs_read | avs_write) & s_q.ack;
    wr_go = commit & avs_write & avs_byteenable[0];
    rd_go = commit & avs_read;
    wake = 1'b0;
    pop = 1'b0;
    stat_now = '0;
    stat_now[ST_PEND] = (s_q.msg_cnt != '0); // see (R3)
    stat_now[ST_OVF] = s_q.overflow;
    stat_now[ST_TXFREE] = s_q.tx_free;
    stat_now[ST_TXDONE] = s_q.tx_complete;
    stat_now[ST_RXACT] = s_q.waiting | eng_ev.rx_busy; // see (R9)
    stat_now[ST_TXACT] = s_q.waiting | eng_ev.tx_busy; // see (R9)
    stat_now[ST_WARN] = s_q.err_warn;
    stat_now[ST_BOFF] = s_q.bus_off;
    unique case (idx)
      IDX_CTRL: rd_mux = {3'h0, s_q.sleep, 3'h0, s_q.reset_mode};
      IDX_STAT: rd_mux = stat_now;
      IDX_EVT: rd_mux = s_q.events;
      IDX_EN: rd_mux = s_q.enable;
      IDX_EWL: rd_mux = s_q.warn_limit;
      IDX_REC: rd_mux = s_q.rec;
      IDX_TEC: rd_mux = s_q.tec[7:0]; // see (R6)
      default: rd_mux = 8'h00;
    endcase

    // Bus handshake: one wait cycle, then one ready cycle
    s_d.ack = (avs_read | avs_write) & ~s_q.ack;
    s_d.wait_req = ~s_d.ack;
    if (s_d.ack && avs_read) begin
      s_d.rdata = rd_mux;
    end

    // One-cycle command pulses
    s_d.ctl.tx_req = 1'b0;
    s_d.ctl.self_loop = 1'b0;
    s_d.ctl.abort = 1'b0;
    s_d.ctl.buf_we = 1'b0;
    s_d.ctl.rx_release = 1'b0;
    s_d.blank = 1'b0;

    // Clears first, so that same-cycle sets below win
    if (rd_go && idx == IDX_EVT) begin
      // Only flags the host has seen; ones set during the wait cycle stay
      s_d.events[7:1] = s_q.events[7:1] & ~s_q.rdata[7:1]; // see (R14)
    end
    if (wr_go && idx == IDX_CMD) begin
      if (wdat[CMD_TX] || wdat[CMD_SELF]) begin
        s_d.tx_complete = 1'b0; // see (R10)
        if (s_q.tx_free && !s_q.reset_mode) begin
          s_d.ctl.tx_req = 1'b1;
          s_d.ctl.self_loop = wdat[CMD_SELF] & ~wdat[CMD_TX];
          s_d.tx_free = 1'b0;
        end
      end
      s_d.ctl.abort = wdat[CMD_ABORT];
      if (wdat[CMD_RELEASE]) begin
        s_d.blank = 1'b1; // see (R23)
        pop = (s_q.msg_cnt != '0);
        s_d.ctl.rx_release = pop;
      end
      if (wdat[CMD_CLR_OVF]) begin
        s_d.overflow = 1'b0; // see (R2)
      end
    end
    if (wr_go && idx == IDX_CTRL) begin
      s_d.reset_mode = wdat[CTRL_RESET];
      if (s_q.bus_off && !wdat[CTRL_RESET]) begin
        s_d.recovering = 1'b1; // see (R5)
      end
      if (wdat[CTRL_SLEEP] && !s_q.sleep) begin
        if (eng_ev.rx_busy || eng_ev.tx_busy || eng_ev.bus_activity ||
            s_q.irq) begin
          wake = 1'b1; // see (R24)
        end else begin
          s_d.sleep = 1'b1;
        end
      end else begin
        s_d.sleep = wdat[CTRL_SLEEP];
      end
    end
    if (wr_go && idx == IDX_EN) begin
      s_d.enable = wdat;
    end
    if (wr_go && idx == IDX_EWL) begin
      s_d.warn_limit = wdat;
    end
    if (wr_go && idx >= IDX_TXB_FIRST && idx <= IDX_TXB_LAST) begin
      // A locked buffer drops the byte without any trace
      if (s_q.tx_free) begin // see (R11)
        s_d.ctl.buf_we = 1'b1;
        s_d.ctl.buf_idx = 4'(idx - IDX_TXB_FIRST);
        s_d.ctl.buf_data = wdat;
      end
    end

    // Wake from sleep on bus activity
    if (s_q.sleep && eng_ev.bus_activity) begin
      s_d.sleep = 1'b0;
      wake = 1'b1; // see (R18)
    end

    // Transmit buffer
    if (eng_ev.tx_sent) begin
      s_d.tx_complete = 1'b1; // see (R10)
      s_d.tx_free = 1'b1;
    end
    if (eng_ev.tx_aborted) begin
      s_d.tx_free = 1'b1;
    end

    // Receive queue bookkeeping; room is judged before the release
    if (pop) begin
      s_d.used = s_q.used - UW'(s_q.lens[s_q.head]);
      s_d.head = PW'(s_q.head + 1'b1);
    end
    fits = (8'(eng_ev.rx_msg_len) <= 8'(RXQ_BYTES) - 8'(s_q.used)) &&
           (s_q.msg_cnt < (PW + 1)'(RXQ_MSGS));
    // Only a completed frame arrives here, so errored frames never overflow
    if (eng_ev.rx_msg_done) begin // see (R12)
      if (fits) begin
        s_d.lens[s_q.tail] = eng_ev.rx_msg_len;
        s_d.tail = PW'(s_q.tail + 1'b1);
        s_d.used = s_d.used + UW'(eng_ev.rx_msg_len);
      end else begin
        s_d.overflow = 1'b1; // see (R1)
      end
    end
    s_d.msg_cnt = s_q.msg_cnt + (PW + 1)'(eng_ev.rx_msg_done && fits) -
                  (PW + 1)'(pop);

    // Error counters, frozen while bus-off apart from the TEC count-down in recovery
    tec_sum = {1'b0, s_q.tec} + (eng_ev.tx_err ? TEC_ERR_STEP : 10'h000) -
              10'((eng_ev.tx_ok && s_q.tec != '0) ? 1 : 0);
    rec_sum = {1'b0, s_q.rec} + 9'(eng_ev.rx_err) -
              9'((eng_ev.rx_ok && s_q.rec != '0) ? 1 : 0);
    if (!s_q.bus_off) begin
      if (tec_sum > TEC_LIMIT) begin // see (R4)
        s_d.bus_off = 1'b1;
        s_d.reset_mode = 1'b1;
        s_d.tec = TEC_BOFF_LOAD;
        s_d.rec = '0;
        s_d.waiting = 1'b1; // see (R8)
        s_d.recovering = 1'b0;
        s_d.free_cnt = '0;
      end else begin
        s_d.tec = tec_sum[8:0];
        s_d.rec = rec_sum[8] ? REC_MAX : rec_sum[7:0];
      end
    end else if (s_q.recovering && eng_ev.bus_free) begin
      // Counting down shows recovery progress to software
      s_d.free_cnt = s_q.free_cnt + 8'h01; // see (R5)
      s_d.tec = (s_q.tec != '0) ? s_q.tec - 9'h001 : s_q.tec; // see (R6)
      if (s_d.free_cnt == RECOVER_FREE) begin // see (R8)
        s_d.bus_off = 1'b0; // see (R6)
        s_d.recovering = 1'b0;
        s_d.waiting = 1'b0;
        s_d.tec = '0;
        s_d.rec = '0;
      end
    end
    if (!s_d.bus_off && s_q.waiting && eng_ev.bus_free) begin
      s_d.waiting = 1'b0; // see (R8)
    end

    // Derived status
    s_d.err_warn = (s_d.tec >= {1'b0, s_d.warn_limit}) ||
                   (s_d.rec >= s_d.warn_limit); // see (R7)
    s_d.passive = (s_d.tec > PASSIVE_LEVEL) ||
                  ({1'b0, s_d.rec} > PASSIVE_LEVEL);

    // Event flags, sets after clears
    if (eng_ev.bus_err && s_q.enable[EV_BERR]) begin
      s_d.events[EV_BERR] = 1'b1; // see (R15)
    end
    if (eng_ev.arb_loss && s_q.enable[EV_ARB]) begin
      s_d.events[EV_ARB] = 1'b1; // see (R16)
    end
    if ((s_d.passive != s_q.passive) && s_q.enable[EV_PASSIVE]) begin
      s_d.events[EV_PASSIVE] = 1'b1; // see (R17)
    end
    if (wake && s_q.enable[EV_WAKE]) begin
      s_d.events[EV_WAKE] = 1'b1; // see (R18)
    end
    // Rising edge only, so a held overflow raises nothing more
    if (s_d.overflow && !s_q.overflow && s_q.enable[EV_OVF]) begin
      s_d.events[EV_OVF] = 1'b1; // see (R19) (R25)
    end
    if (((s_d.err_warn != s_q.err_warn) || (s_d.bus_off != s_q.bus_off)) &&
        s_q.enable[EV_WARN]) begin
      s_d.events[EV_WARN] = 1'b1; // see (R20) (R4) (R6)
    end
    if (s_d.tx_free && !s_q.tx_free && s_q.enable[EV_TX]) begin
      s_d.events[EV_TX] = 1'b1; // see (R21)
    end
    s_d.events[EV_RX] = s_d.enable[EV_RX] && (s_d.msg_cnt != '0) &&
                        !s_d.blank; // see (R22) (R23)
    s_d.irq = |s_d.events; // see (R13)
    s_d.ctl.reset_mode = s_d.reset_mode;
    s_d.ctl.sleep = s_d.sleep;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.reset_mode <= 1'b1;
      s_q.wait_req <= 1'b1;
      s_q.ctl.reset_mode <= 1'b1;
      s_q.warn_limit <= EWL_RESET; // see (R7)
      s_q.enable <= EN_RESET;
      s_q.tx_free <= 1'b1;
      s_q.tx_complete <= 1'b1;
      s_q.waiting <= 1'b1; // see (R8)
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = {24'h000000, s_q.rdata};
  assign avs_waitrequest = s_q.wait_req;
  assign tx_ctl = s_q.ctl;
  assign bus_off_out = s_q.bus_off;
  assign irq = s_q.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_bus_answer_one: assert property (
    ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop after one cycle");
  a_irq_tracks_flags: assert property (irq == (|s_q.events)) // see (R13)
    else $error("interrupt output disagrees with event flags");
  a_busoff_entry: assert property ($rose(s_q.bus_off) |-> // see (R4)
    s_q.tec == TEC_BOFF_LOAD && s_q.rec == '0 && s_q.reset_mode)
    else $error("bus-off entry did not load counters");
  a_recovery_end: assert property ($fell(s_q.bus_off) |-> // see (R6)
    s_q.tec == '0 && s_q.rec == '0 && $past(s_q.free_cnt) == 8'h7f)
    else $error("bus-off recovery ended wrongly");
  a_overflow_holds: assert property (ce && s_q.overflow && // see (R2)
    !(wr_go && idx == IDX_CMD && wdat[CMD_CLR_OVF]) |=> s_q.overflow)
    else $error("overflow status dropped without clear");
  a_rx_event_empty: assert property ( // see (R22)
    s_q.msg_cnt == '0 |-> !s_q.events[EV_RX])
    else $error("receive event set with empty queue");
  a_read_clears: assert property (ce && rd_go && idx == IDX_EVT && // see (R14)
    s_q.enable[7:1] == 7'h00 |=> s_q.events[7:1] == 7'h00)
    else $error("event read did not clear flags");
  a_txb_discard: assert property (ce && wr_go && !s_q.tx_free && // see (R11)
    idx >= IDX_TXB_FIRST && idx <= IDX_TXB_LAST |=> !tx_ctl.buf_we)
    else $error("locked transmit buffer accepted a byte");
  a_txdone_clear: assert property (ce && wr_go && idx == IDX_CMD && // see (R10)
    (wdat[CMD_TX] || wdat[CMD_SELF]) && !eng_ev.tx_sent
    |=> !s_q.tx_complete)
    else $error("transmit complete not cleared by request");
  a_warn_level: assert property (s_q.err_warn == // see (R7)
    ((s_q.tec >= {1'b0, s_q.warn_limit}) || (s_q.rec >= s_q.warn_limit)))
    else $error("warning status disagrees with counters");
  a_wait_both_set: assert property ( // see (R9)
    s_q.waiting |-> stat_now[ST_RXACT] && stat_now[ST_TXACT])
    else $error("waiting for idle without both active bits");
  a_release_blank: assert property (ce && wr_go && idx == IDX_CMD && // see (R23)
    wdat[CMD_RELEASE] |=> !s_q.events[EV_RX])
    else $error("release did not blank receive event");

endmodule : cse_status_events

`default_nettype wire

// >>> verification/cse_engine_model.sv
// Purpose: Behavioural frame engine facing the status/event block.
// Assumes: Pulses last one sys_clk cycle and start after a rising edge.
// Notes:   tx_wait sets how slowly a requested transmission completes.
`default_nettype none

module cse_engine_model
  import cse_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Block side
  input wire cse_tx_ctl_t tx_ctl,
  output var cse_engine_ev_t eng_ev
);
  timeunit 1ns;
  timeprecision 100ps;

  cse_engine_ev_t pul_q = '0;
  logic busy_q = 1'b0;
  logic sent_q = 1'b0;
  int tx_wait = 2;

  // ****************************************
  // Event pulses
  // ****************************************
  // Idle gap between pulses keeps each one a separate event
  task automatic pulse(input cse_engine_ev_t p, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      pul_q <= p;
      @(posedge sys_clk);
      pul_q <= '0;
    end
  endtask : pulse

  // ****************************************
  // Transmit answer
  // ****************************************
  always begin
    @(posedge sys_clk);
    if (tx_ctl.tx_req === 1'b1 || tx_ctl.self_loop === 1'b1) begin
      busy_q <= 1'b1;
      repeat (tx_wait) @(posedge sys_clk);
      sent_q <= 1'b1;
      @(posedge sys_clk);
      sent_q <= 1'b0;
      busy_q <= 1'b0;
    end
  end

  always_comb begin
    eng_ev = pul_q;
    eng_ev.tx_busy = busy_q;
    eng_ev.tx_sent = sent_q;
    eng_ev.tx_ok = pul_q.tx_ok | sent_q;
  end

endmodule : cse_engine_model

`default_nettype wire

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the CAN status/event block.
// Assumes: ce held high except around one bus error pulse in t_err; full byte enables on every access.
// Notes:   Expected values are worked out from reset values and counts.
`default_nettype none

module testbench
  import cse_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  cse_engine_ev_t eng_ev;
  cse_tx_ctl_t tx_ctl;
  logic bus_off;
  logic irq;
  logic [7:0] rd;
  cse_engine_ev_t e_free, e_msg, e_berr, e_arb, e_rxerr, e_txerr, e_act;
  logic ce = 1'b1;
  logic [7:0] last_data = 8'h00;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int we_count = 0;

  cse_status_events #(.RXQ_BYTES(64), .RXQ_MSGS(8)) uut (
    .sys_clk(sys_clk), .reset_n(reset_n), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .eng_ev(eng_ev), .tx_ctl(tx_ctl), .bus_off_out(bus_off), .irq(irq)
  );

  cse_engine_model eng (.sys_clk(sys_clk), .tx_ctl(tx_ctl), .eng_ev(eng_ev));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Monitor and hang guard
  // ****************************************
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (tx_ctl.buf_we === 1'b1) begin
      we_count <= we_count + 1;
      last_data <= tx_ctl.buf_data;
    end
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim;
    $display("Checks: %0d mismatches: %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rc(input logic [5:0] idx, input logic [7:0] mask,
                    input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rd & mask, exp);
  endtask : rc

  task automatic wait_free;
    rd = 8'h00;
    for (int i = 0; i < 40 && rd[ST_TXFREE] !== 1'b1; i++) begin
      bus(1'b0, IDX_STAT, 8'h00);
    end
  endtask : wait_free

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rc(IDX_STAT, 8'hff, 8'h3c);
    rc(IDX_CTRL, 8'hff, 8'h01);
    rc(IDX_EWL, 8'hff, 8'h60);
    rc(IDX_EN, 8'hff, 8'h00);
    rc(IDX_EVT, 8'hff, 8'h00);
    bus(1'b1, IDX_STAT, 8'h00);
    bus(1'b1, 6'h3f, 8'hff);
    rc(6'h3f, 8'hff, 8'h00);
    rc(IDX_STAT, 8'hff, 8'h3c);
    bus(1'b1, IDX_EWL, 8'h21);
    rc(IDX_EWL, 8'hff, 8'h21);
    bus(1'b1, IDX_EWL, EWL_RESET);
    eng.pulse(e_free, 1);
    rc(IDX_STAT, 8'hff, 8'h0c);
    check({7'h0, irq}, 8'h00);
  endtask : t_reset

  task automatic t_rx;
    eng.pulse(e_msg, 2);
    rc(IDX_STAT, 8'hff, 8'h0d);
    bus(1'b1, IDX_CTRL, 8'h10);
    rc(IDX_CTRL, 8'hff, 8'h00);
    rc(IDX_EVT, 8'hff, 8'h11);
    rc(IDX_EVT, 8'hff, 8'h01);
    check({7'h0, irq}, 8'h01);
    bus(1'b1, IDX_CMD, 8'h04);
    rc(IDX_EVT, 8'hff, 8'h01);
    bus(1'b1, IDX_CMD, 8'h04);
    rc(IDX_STAT, 8'hff, 8'h0c);
    rc(IDX_EVT, 8'hff, 8'h00);
    check({7'h0, irq}, 8'h00);
    bus(1'b1, IDX_CTRL, 8'h10);
    rc(IDX_CTRL, 8'hff, 8'h10);
    check({7'h0, tx_ctl.sleep}, 8'h01);
    eng.pulse(e_act, 1);
    rc(IDX_CTRL, 8'hff, 8'h00);
    rc(IDX_EVT, 8'hff, 8'h10);
  endtask : t_rx

  task automatic t_ovf;
    eng.pulse(e_msg, 9);
    rc(IDX_STAT, 8'hff, 8'h0f);
    rc(IDX_EVT, 8'hff, 8'h09);
    eng.pulse(e_msg, 1);
    rc(IDX_EVT, 8'hff, 8'h01);
    bus(1'b1, IDX_CMD, 8'h08);
    eng.pulse(e_rxerr, 1);
    rc(IDX_STAT, 8'hff, 8'h0d);
    repeat (8) bus(1'b1, IDX_CMD, 8'h04);
    rc(IDX_STAT, 8'hff, 8'h0c);
  endtask : t_ovf

  task automatic t_tx;
    bus(1'b1, IDX_TXB_FIRST, 8'h5a);
    // Strobe stands the cycle after the ack edge; the count lands one later
    repeat (2) @(posedge sys_clk);
    check(8'(we_count), 8'h01);
    check(last_data, 8'h5a);
    eng.tx_wait = 40;
    bus(1'b1, IDX_CMD, 8'h01);
    rc(IDX_STAT, 8'h0c, 8'h00);
    bus(1'b1, IDX_TXB_FIRST, 8'ha5);
    repeat (2) @(posedge sys_clk);
    check(8'(we_count), 8'h01);
    check(last_data, 8'h5a);
    wait_free();
    rc(IDX_STAT, 8'h0c, 8'h0c);
    rc(IDX_EVT, 8'hff, 8'h02);
    eng.tx_wait = 8;
    bus(1'b1, IDX_CMD, 8'h10);
    rc(IDX_STAT, 8'h08, 8'h00);
    wait_free();
    rc(IDX_STAT, 8'h0c, 8'h0c);
    rc(IDX_EVT, 8'hff, 8'h02);
  endtask : t_tx

  task automatic t_err;
    bus(1'b1, IDX_EN, 8'h7f);
    eng.pulse(e_berr, 1);
    eng.pulse(e_arb, 1);
    rc(IDX_EVT, 8'hff, 8'h40);
    bus(1'b1, IDX_EN, 8'hff);
    eng.pulse(e_berr, 1);
    rc(IDX_EVT, 8'hff, 8'h80);
    // Enable low: the bus error must leave no trace
    ce <= 1'b0;
    eng.pulse(e_berr, 1);
    @(posedge sys_clk);
    ce <= 1'b1;
    rc(IDX_EVT, 8'hff, 8'h00);
  endtask : t_err

  task automatic t_boff;
    eng.pulse(e_txerr, 12);
    rc(IDX_STAT, 8'h40, 8'h40);
    rc(IDX_EVT, 8'hff, 8'h04);
    eng.pulse(e_txerr, 4);
    rc(IDX_EVT, 8'hff, 8'h20);
    eng.pulse(e_txerr, 16);
    rc(IDX_STAT, 8'hff, 8'hfc);
    rc(IDX_CTRL, 8'h01, 8'h01);
    rc(IDX_TEC, 8'hff, 8'h7f);
    rc(IDX_REC, 8'hff, 8'h00);
    rc(IDX_EVT, 8'h04, 8'h04);
    check({7'h0, bus_off}, 8'h01);
    bus(1'b1, IDX_CTRL, 8'h00);
    eng.pulse(e_free, 28);
    rc(IDX_TEC, 8'hff, 8'h63);
    eng.pulse(e_free, 99);
    rc(IDX_STAT, 8'h80, 8'h80);
    eng.pulse(e_free, 1);
    rc(IDX_STAT, 8'hff, 8'h0c);
    rc(IDX_TEC, 8'hff, 8'h00);
    rc(IDX_EVT, 8'h04, 8'h04);
  endtask : t_boff

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    e_free = '0;
    e_free.bus_free = 1'b1;
    e_msg = '0;
    e_msg.rx_msg_done = 1'b1;
    e_msg.rx_msg_len = 7'h05;
    e_berr = '0;
    e_berr.bus_err = 1'b1;
    e_arb = '0;
    e_arb.arb_loss = 1'b1;
    e_rxerr = '0;
    e_rxerr.rx_err = 1'b1;
    e_txerr = '0;
    e_txerr.tx_err = 1'b1;
    e_act = '0;
    e_act.bus_activity = 1'b1;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    bus(1'b1, IDX_EN, 8'hff);
    t_rx();
    t_ovf();
    t_tx();
    t_err();
    t_boff();
    end_sim();
  end

endmodule : testbench

`default_nettype wire
